// ---- hbpwm_bridge.sv ----
`timescale 1ns/1ps
module hbpwm_bridge
(
  // Fault request from the bench
  input wire logic fault,
  // Active-low trip flag, driven both high and low
  output logic ntrip
);
  // Overcurrent flag pulls the trip line low
  assign ntrip = ~fault;
endmodule // hbpwm_bridge

// ---- hbpwm_pkg.sv ----
package hbpwm_pkg;

  // Widths and counts
  localparam int unsigned HBPWM_CNT_W = 16;
  localparam int unsigned HBPWM_PRE_W = 8;
  localparam int unsigned HBPWM_NUM_TIMERS = 3;
  localparam int unsigned HBPWM_NUM_CMP = 8;

  // Register byte addresses
  localparam logic [31:0] HBPWM_OFS_CONTROL = 32'hffff0f80;
  localparam logic [31:0] HBPWM_OFS_CMP [HBPWM_NUM_CMP] = '{
    32'hffff0f84, 32'hffff0f88, 32'hffff0f8c,
    32'hffff0f94, 32'hffff0f98, 32'hffff0f9c,
    32'hffff0fa4, 32'hffff0fa8};
  localparam logic [31:0] HBPWM_OFS_PERIOD [HBPWM_NUM_TIMERS] = '{
    32'hffff0f90, 32'hffff0fa0, 32'hffff0fac};
  localparam logic [31:0] HBPWM_OFS_STATUS = 32'hffff0fb4;
  localparam logic [31:0] HBPWM_OFS_INT_CLEAR = 32'hffff0fb8;

  // Control field positions
  localparam int unsigned HBPWM_BIT_SYNC_EN = 14;
  localparam int unsigned HBPWM_BIT_INV_P1_LOW = 12;
  localparam int unsigned HBPWM_BIT_INV_P0_LOW = 11;
  localparam int unsigned HBPWM_BIT_TRIP_EN = 10;
  localparam int unsigned HBPWM_BIT_BRIDGE_ENA = 9;
  localparam int unsigned HBPWM_BIT_PRESC_LSB = 6;
  localparam int unsigned HBPWM_BIT_GLOBAL_INV = 5;
  localparam int unsigned HBPWM_BIT_HIGH_OFF = 4;
  localparam int unsigned HBPWM_BIT_CMP_LOAD = 3;
  localparam int unsigned HBPWM_BIT_DIR = 2;
  localparam int unsigned HBPWM_BIT_BRIDGE_MODE = 1;
  localparam int unsigned HBPWM_BIT_OUT_EN = 0;

  // Values after reset and write masks
  localparam logic [15:0] HBPWM_CONTROL_RESET = 16'h0012;
  localparam logic [15:0] HBPWM_CONTROL_WMASK = 16'h5fff;
  localparam logic [15:0] HBPWM_CMP_RESET = 16'h0000;
  localparam logic [15:0] HBPWM_PERIOD_RESET = 16'hffff;

  // Register bus request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [31:0] addr;
    logic [31:0] wdata;
  } hbpwm_bus_req_type;

  // Whole state of the unit
  typedef struct packed {
    logic [15:0] ctrl;
    logic [HBPWM_NUM_TIMERS-1:0][15:0] period;
    logic [HBPWM_NUM_CMP-1:0][15:0] cmp_prog;
    logic [HBPWM_NUM_CMP-1:0][15:0] cmp_act;
    logic [HBPWM_NUM_TIMERS-1:0][HBPWM_CNT_W-1:0] cnt;
    logic [HBPWM_PRE_W-1:0] pre;
    logic [2:0] sync_ff;
    logic [1:0] trip_ff;
    logic [HBPWM_NUM_TIMERS-1:0] hs;
    logic [1:0] ls;
    logic pend;
    logic [4:0] outs;
    logic [31:0] rdata;
  } hbpwm_state_type;

endpackage

// ---- hbpwm_unit.sv ----
// Local design decision: strobed register access.
`timescale 1ns/1ps
// Notes on behaviour
// [RULE_01] Five PWM outputs, usable for an H-bridge or as plain PWM.
// [RULE_02] After reset the unit sits in H-bridge mode with motor held off.
// [RULE_03] Standard mode: two pairs and the single output, own period each, own duty per output.
// [RULE_04] Compare registers set the counts where outputs change state.
// [RULE_05] Timer clock is system clock divided by 2 up to 256.
// [RULE_06] Each pair runs a 16-bit counter wrapping at its period register.
// [RULE_07] High side rises at first compare, falls at second compare.
// [RULE_08] Low side rises at period, falls at third compare or high fall.
// [RULE_09] Fifth output uses its own two compare registers.
// [RULE_10] Control register is 16-bit read/write, resets to 0x0012.
// [RULE_11] Sync enable: falling sync pin resets all counters next edge; here they clear on the third clock edge after the fall.
// [RULE_12] Software writes zero to reserved control bit 13.
// [RULE_13] Bit 12 inverts the second pair low side.
// [RULE_14] Bit 11 inverts the first pair low side.
// [RULE_15] Trip enable with trip pin low clears enable, raises interrupt.
// [RULE_16] Bit 9 gates outputs only in H-bridge mode with high-off clear.
// [RULE_17] A separate register exists only to clear the pending interrupt.
// [RULE_18] Bits 8 to 6 pick divider, 000 is /2 up to 111 /256.
// [RULE_19] Bit 4 forces high sides high and low sides low.
// [RULE_20] Bit 3 loads active compares at next timer step 0 to 1.
// [RULE_21] Any write to the clear register clears the trip interrupt; here not while trip is enabled and the trip pin is low.
// [RULE_22] Bit 1 selects H-bridge mode, bit 0 enables all outputs.
// [RULE_23] H-bridge: direction and inversion pick driven pair, other held fixed.
module hbpwm_unit
  import hbpwm_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Register port
  input wire hbpwm_bus_req_type bus_req,
  output logic [31:0] bus_rdata,
  // Pins from outside
  input wire logic sync_pin,
  input wire logic trip_input_pin,
  // PWM outputs
  output logic pair0_high_out,
  output logic pair0_low_out,
  output logic pair1_high_out,
  output logic pair1_low_out,
  output logic single_out,
  // Trip interrupt
  output logic trip_irq
);

  hbpwm_state_type s_reg;
  hbpwm_state_type s_next;
  logic [HBPWM_PRE_W-1:0] pre_mask;
  logic tick;
  logic sync_fire;
  logic trip_hit;
  logic clr_hit;
  logic [3:0] widx;
  logic [3:0] ridx;
  logic [1:0] pwidx;
  logic [1:0] pridx;
  logic [HBPWM_NUM_TIMERS-1:0] load_go;
  logic [15:0] ctl;
  logic hs_fall;
  logic [4:0] outs_next;

  // Compare register index from address, 4'hf when none
  function automatic logic [3:0] cmp_index(input logic [31:0] a);
    logic [3:0] r;
    r = 4'hf;
    for (int i = 0; i < HBPWM_NUM_CMP; i++)
    begin
      if (a == HBPWM_OFS_CMP[i])
      begin
        r = i[3:0];
      end
    end
    return r;
  endfunction

  // Period register index from address, 2'h3 when none
  function automatic logic [1:0] period_index(input logic [31:0] a);
    logic [1:0] r;
    r = 2'h3;
    for (int i = 0; i < HBPWM_NUM_TIMERS; i++)
    begin
      if (a == HBPWM_OFS_PERIOD[i])
      begin
        r = i[1:0];
      end
    end
    return r;
  endfunction

  // Timer that owns a compare register
  function automatic int cmp_timer(input int i);
    return (i < 3) ? 0 : ((i < 6) ? 1 : 2);
  endfunction

  // Address decode shared by write and read paths
  assign widx = cmp_index(bus_req.addr);
  assign ridx = widx;
  assign pwidx = period_index(bus_req.addr);
  assign pridx = pwidx;

  // Prescaler tick: low sel+1 bits all ones gives divide by 2^(sel+1)
  assign pre_mask = HBPWM_PRE_W'((9'h002 << s_reg.ctrl[HBPWM_BIT_PRESC_LSB +: 3]) - 9'h001); // RULE_18
  assign tick = (s_reg.pre & pre_mask) == pre_mask; // RULE_05

  // Falling edge seen between the second and third sync stages
  assign sync_fire = s_reg.ctrl[HBPWM_BIT_SYNC_EN] & s_reg.sync_ff[2] & ~s_reg.sync_ff[1]; // RULE_11

  // Trip pin low after synchronising, while trip is enabled
  assign trip_hit = s_reg.ctrl[HBPWM_BIT_TRIP_EN] & ~s_reg.trip_ff[1]; // RULE_15
  assign clr_hit = bus_req.wr & (bus_req.addr == HBPWM_OFS_INT_CLEAR); // RULE_17

  // Next state
  always_comb
  begin
    s_next = s_reg;
    load_go = '0;
    hs_fall = 1'b0;
    ctl = s_reg.ctrl;
    outs_next = '0;

    // Free running prescale counter
    s_next.pre = s_reg.pre + 8'h01;

    // Pin synchronisers; first stage feeds only the second
    s_next.sync_ff = {s_reg.sync_ff[1:0], sync_pin};
    s_next.trip_ff = {s_reg.trip_ff[0], trip_input_pin};

    // Timers wrap after reaching their period
    for (int t = 0; t < HBPWM_NUM_TIMERS; t++)
    begin
      if (sync_fire)
      begin
        s_next.cnt[t] = '0; // RULE_11
      end
      else if (tick)
      begin
        if (s_reg.cnt[t] >= s_reg.period[t])
        begin
          s_next.cnt[t] = '0; // RULE_06
        end
        else
        begin
          s_next.cnt[t] = s_reg.cnt[t] + 16'h0001; // RULE_06
          load_go[t] = (s_reg.cnt[t] == 16'h0000) & s_reg.ctrl[HBPWM_BIT_CMP_LOAD]; // RULE_20
        end
      end
    end

    // Active compares follow programmed ones only on the 0 to 1 step
    for (int i = 0; i < HBPWM_NUM_CMP; i++)
    begin
      if (load_go[cmp_timer(i)])
      begin
        s_next.cmp_act[i] = s_reg.cmp_prog[i]; // RULE_20
      end
    end

    // High side waveforms; fall wins when both compares match
    for (int p = 0; p < HBPWM_NUM_TIMERS; p++)
    begin
      if (s_reg.cnt[p] == s_reg.cmp_act[3*p+1])
      begin
        s_next.hs[p] = 1'b0; // RULE_07 RULE_09
      end
      else if (s_reg.cnt[p] == s_reg.cmp_act[3*p])
      begin
        s_next.hs[p] = 1'b1; // RULE_07 RULE_09
      end
    end

    // Low side waveforms of the two pairs
    for (int p = 0; p < 2; p++)
    begin
      hs_fall = s_reg.hs[p] & ~s_next.hs[p];
      if (hs_fall || (s_reg.cnt[p] == s_reg.cmp_act[3*p+2]))
      begin
        s_next.ls[p] = 1'b0; // RULE_08
      end
      else if (s_reg.cnt[p] == s_reg.period[p])
      begin
        s_next.ls[p] = 1'b1; // RULE_08
      end
    end

    // Register writes; reserved bits 13 and 15 never stored
    if (bus_req.wr)
    begin
      if (bus_req.addr == HBPWM_OFS_CONTROL)
      begin
        s_next.ctrl = bus_req.wdata[15:0] & HBPWM_CONTROL_WMASK; // RULE_10 RULE_12
      end
      else if (widx != 4'hf)
      begin
        s_next.cmp_prog[widx[2:0]] = bus_req.wdata[15:0]; // RULE_04
      end
      else if (pwidx != 2'h3)
      begin
        s_next.period[pwidx] = bus_req.wdata[15:0]; // RULE_03
      end
    end

    // Trip beats a same-cycle control write and a same-cycle clear
    if (clr_hit)
    begin
      s_next.pend = 1'b0; // RULE_21
    end
    if (trip_hit)
    begin
      s_next.ctrl[HBPWM_BIT_OUT_EN] = 1'b0; // RULE_15
      s_next.pend = 1'b1; // RULE_15
    end

    // Output selection from the current waveforms
    if (ctl[HBPWM_BIT_HIGH_OFF])
    begin
      outs_next[3:0] = 4'b0101; // RULE_19 RULE_02
      outs_next[4] = ctl[HBPWM_BIT_OUT_EN] & s_reg.hs[2];
    end
    else if (ctl[HBPWM_BIT_BRIDGE_MODE])
    begin
      outs_next[4] = ctl[HBPWM_BIT_OUT_EN] & s_reg.hs[2];
      if (!ctl[HBPWM_BIT_BRIDGE_ENA] || !ctl[HBPWM_BIT_OUT_EN])
      begin
        outs_next[3:0] = 4'b1111; // RULE_16
      end
      else
      begin
        case ({ctl[HBPWM_BIT_GLOBAL_INV], ctl[HBPWM_BIT_DIR]}) // RULE_23
          2'b00: outs_next[3:0] = {s_reg.ls[0], s_reg.hs[0], 2'b00};
          2'b01: outs_next[3:0] = {2'b00, s_reg.ls[0], s_reg.hs[0]};
          2'b10: outs_next[3:0] = {2'b11, s_reg.ls[0], s_reg.hs[0]};
          default: outs_next[3:0] = {s_reg.ls[0], s_reg.hs[0], 2'b11};
        endcase
      end
    end
    else if (ctl[HBPWM_BIT_OUT_EN])
    begin
      // Standard mode: each pair and the single output run on their own
      outs_next = {s_reg.hs[2],
                   s_reg.ls[1] ^ ctl[HBPWM_BIT_INV_P1_LOW],
                   s_reg.hs[1],
                   s_reg.ls[0] ^ ctl[HBPWM_BIT_INV_P0_LOW],
                   s_reg.hs[0]} ^ {5{ctl[HBPWM_BIT_GLOBAL_INV]}}; // RULE_03 RULE_13 RULE_14
    end
    else
    begin
      outs_next = 5'h00; // RULE_22
    end
    s_next.outs = outs_next; // RULE_01

    // Read data stands only in the cycle after the strobe
    s_next.rdata = 32'h00000000;
    if (bus_req.rd)
    begin
      if (bus_req.addr == HBPWM_OFS_CONTROL)
      begin
        s_next.rdata = {16'h0000, s_reg.ctrl}; // RULE_10
      end
      else if (ridx != 4'hf)
      begin
        s_next.rdata = {16'h0000, s_reg.cmp_prog[ridx[2:0]]};
      end
      else if (pridx != 2'h3)
      begin
        s_next.rdata = {16'h0000, s_reg.period[pridx]};
      end
      else if (bus_req.addr == HBPWM_OFS_STATUS)
      begin
        s_next.rdata = {25'h0000000, s_reg.outs, ~s_reg.trip_ff[1], s_reg.pend};
      end
    end
  end

  // State register; reset values are constants only
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      s_reg <= '0;
      s_reg.ctrl <= HBPWM_CONTROL_RESET; // RULE_02 RULE_10
      s_reg.period <= {HBPWM_NUM_TIMERS{HBPWM_PERIOD_RESET}};
      s_reg.cmp_prog <= {HBPWM_NUM_CMP{HBPWM_CMP_RESET}};
      s_reg.cmp_act <= {HBPWM_NUM_CMP{HBPWM_CMP_RESET}};
      s_reg.sync_ff <= 3'b111;
      s_reg.trip_ff <= 2'b11;
      s_reg.outs <= 5'b00101; // RULE_02
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  // Outputs straight from flip-flops
  assign bus_rdata = s_reg.rdata;
  assign pair0_high_out = s_reg.outs[0];
  assign pair0_low_out = s_reg.outs[1];
  assign pair1_high_out = s_reg.outs[2];
  assign pair1_low_out = s_reg.outs[3];
  assign single_out = s_reg.outs[4];
  assign trip_irq = s_reg.pend; // RULE_15

endmodule // hbpwm_unit

// ---- hbpwm_unit_asserts.sv ----
`timescale 1ns/1ps
module hbpwm_unit_chk
  import hbpwm_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Register port
  input wire hbpwm_bus_req_type bus_req,
  input wire logic [31:0] bus_rdata,
  // Pins
  input wire logic sync_pin,
  input wire logic trip_input_pin,
  // Outputs
  input wire logic pair0_high_out,
  input wire logic pair0_low_out,
  input wire logic pair1_high_out,
  input wire logic pair1_low_out,
  input wire logic single_out,
  input wire logic trip_irq
);
  logic [15:0] sh_reg;
  logic [2:0] age_reg;
  logic cw, clr;
  logic [3:0] quad;
  assign cw = bus_req.wr && (bus_req.addr == HBPWM_OFS_CONTROL);
  assign clr = bus_req.wr && (bus_req.addr == HBPWM_OFS_INT_CLEAR);
  assign quad = {pair0_high_out, pair0_low_out, pair1_high_out, pair1_low_out};
  // Shadow of written control; trip clearing bit 0 is not mirrored, so only safe uses
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      sh_reg <= HBPWM_CONTROL_RESET;
      age_reg <= 3'h0;
    end
    else
    begin
      if (cw) sh_reg <= bus_req.wdata[15:0];
      age_reg <= cw ? 3'h0 : (age_reg == 3'h7 ? age_reg : age_reg + 3'h1);
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  rdata_idle_a: assert property (!$past(bus_req.rd) |-> bus_rdata == 32'h0)
    else $error("read data outside reply cycle");
  reset_pat_a: assert property (disable iff (1'b0)
    !nrst |-> quad == 4'ha && !single_out && !trip_irq) else $error("bad reset outputs");
  high_side_off_force_a: assert property (age_reg[2] && sh_reg[4] |-> quad == 4'ha)
    else $error("high side off not forced");
  std_off_a: assert property (age_reg[2] && sh_reg[4:0] == 5'h08
    |-> {quad, single_out} == 5'h0) else $error("disabled outputs not low");
  bridge_off_a: assert property (age_reg[2] && sh_reg[1] && !sh_reg[4] && !sh_reg[9]
    |-> quad == 4'hf) else $error("bridge disable not high");
  trip_set_a: assert property ((sh_reg[10] && !trip_input_pin) [*3] |=> trip_irq)
    else $error("trip not raised");
  trip_cause_a: assert property ($rose(trip_irq) |-> !$past(trip_input_pin, 3))
    else $error("interrupt without trip");
  irq_hold_a: assert property (trip_irq && !clr |=> trip_irq)
    else $error("interrupt dropped without clear");
  irq_clear_a: assert property (trip_input_pin [*4] ##0 clr |=> !trip_irq)
    else $error("clear write ignored");
  cover property ($rose(trip_irq));
  cover property (age_reg[2] && sh_reg[1] && sh_reg[9] && !sh_reg[4]);
  cover property (clr && trip_irq);
endmodule // hbpwm_unit_chk

bind hbpwm_unit hbpwm_unit_chk chk (.mclk(mclk), .nrst(nrst), .bus_req(bus_req),
  .bus_rdata(bus_rdata), .sync_pin(sync_pin), .trip_input_pin(trip_input_pin),
  .pair0_high_out(pair0_high_out), .pair0_low_out(pair0_low_out),
  .pair1_high_out(pair1_high_out), .pair1_low_out(pair1_low_out),
  .single_out(single_out), .trip_irq(trip_irq));

// ---- hbpwm_unit_tb.sv ----
`timescale 1ns/1ps
module hbpwm_unit_tb;
  import hbpwm_pkg::*;
  // Bench signals
  logic mclk, nrst, sync_pin, sync_run, fault, ntrip, trip_irq;
  hbpwm_bus_req_type bus_req;
  logic [31:0] bus_rdata, rv;
  logic [4:0] o;
  int errors, total_checks, cyc, rises;
  int cnt [5];
  // Eight compares then three periods
  logic [15:0] lv [11] = '{16'h0002, 16'h0006, 16'h0003, 16'h0000, 16'h0001, 16'h0002,
    16'h0005, 16'h000f, 16'h0009, 16'h0004, 16'h0013};
  // Control values and high cycles per 200; negative is unchecked
  logic [15:0] tc [11] = '{16'h0001, 16'h0009, 16'h1809, 16'h0008, 16'h0019, 16'h020b,
    16'h020f, 16'h022b, 16'h022f, 16'h000b, 16'h0029};
  int te [11][5] = '{'{0, 20, 0, 40, 0}, '{80, 80, 40, 80, 100}, '{80, 120, 40, 120, 100},
    '{0, 0, 0, 0, 0}, '{200, 0, 200, 0, 100}, '{0, 0, 80, 80, 100}, '{80, 80, 0, 0, 100},
    '{80, 80, 200, 200, 100}, '{200, 200, 80, 80, 100}, '{200, 200, 200, 200, 100},
    '{120, 120, 160, 120, 100}};

  hbpwm_unit dut (.mclk(mclk), .nrst(nrst), .bus_req(bus_req), .bus_rdata(bus_rdata),
    .sync_pin(sync_pin), .trip_input_pin(ntrip), .pair0_high_out(o[0]), .pair0_low_out(o[1]),
    .pair1_high_out(o[2]), .pair1_low_out(o[3]), .single_out(o[4]), .trip_irq(trip_irq));
  hbpwm_bridge stage (.fault(fault), .ntrip(ntrip));

  // 250 MHz clock
  initial
  begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  // Hang guard, well above the expected run
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      errors++;
      conclude();
    end
  end
  // Sync toggles every cycle so falls arrive faster than a count step
  always @(posedge mclk)
    sync_pin <= sync_run ? ~sync_pin : 1'b1;

  function automatic logic [31:0] ad(input int i);
    return i < 8 ? HBPWM_OFS_CMP[i] : HBPWM_OFS_PERIOD[i-8];
  endfunction
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task wr(input logic [31:0] a, input logic [15:0] d);
    bus_req <= '{1'b1, 1'b0, a, {16'h0000, d}};
    @(posedge mclk);
    bus_req <= '0;
    @(posedge mclk);
  endtask
  task rd(input logic [31:0] a);
    bus_req <= '{1'b0, 1'b1, a, 32'h0};
    @(posedge mclk);
    bus_req <= '0;
    @(negedge mclk);
    rv = bus_rdata;
    @(posedge mclk);
  endtask
  task ck_irq(input logic e);
    @(negedge mclk);
    chk({31'h0, trip_irq}, {31'h0, e});
    @(posedge mclk);
  endtask
  // High cycles per output and rises of pair0 high over n samples
  task meas(input int n);
    logic pv;
    cnt = '{default: 0};
    rises = 0;
    @(negedge mclk);
    pv = o[0];
    repeat (n)
    begin
      @(negedge mclk);
      for (int k = 0; k < 5; k++) cnt[k] += (o[k] === 1'b1);
      rises += (o[0] === 1'b1 && pv !== 1'b1);
      pv = o[0];
    end
    @(posedge mclk);
  endtask
  task conclude;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    bus_req = '0;
    nrst = 1'b1;
    fault = 1'b0;
    sync_run = 1'b0;
    // Reset falls off time zero so the asynchronous branch surely sees it
    #1 nrst = 1'b0;
    repeat (2) @(posedge mclk);
    nrst <= 1'b1;
    @(posedge mclk);
    rd(HBPWM_OFS_CONTROL);
    chk(rv, 32'h00000012);
    chk({27'h0, o}, 32'h00000005);
    rd(32'hffff0fb0);
    chk(rv, 32'h0);
    rd(HBPWM_OFS_INT_CLEAR);
    chk(rv, 32'h0);
    for (int i = 0; i < 11; i++) wr(ad(i), lv[i]);
    for (int i = 0; i < 11; i++)
    begin
      rd(ad(i));
      chk(rv, {16'h0000, lv[i]});
    end
    $display("test registers done");
    foreach (tc[i])
    begin
      wr(HBPWM_OFS_CONTROL, tc[i]);
      repeat (50) @(posedge mclk);
      meas(200);
      for (int k = 0; k < 5; k++)
        if (te[i][k] >= 0) chk(32'(cnt[k]), 32'(te[i][k]));
    end
    $display("test waveforms done");
    for (int s = 0; s < 4; s++)
    begin
      wr(HBPWM_OFS_CONTROL, 16'h0009 | 16'(s << 6));
      repeat (200) @(posedge mclk);
      meas(640);
      chk(32'(rises), 32'(32 >> s));
    end
    $display("test prescaler done");
    wr(HBPWM_OFS_CONTROL, 16'h4089);
    sync_run <= 1'b1;
    repeat (50) @(posedge mclk);
    meas(800);
    chk(32'(rises), 32'h0);
    wr(HBPWM_OFS_CONTROL, 16'h0089);
    repeat (100) @(posedge mclk);
    meas(800);
    chk(32'(rises), 32'd10);
    sync_run <= 1'b0;
    $display("test sync done");
    wr(HBPWM_OFS_CONTROL, 16'h0409);
    fault <= 1'b1;
    repeat (10) @(posedge mclk);
    ck_irq(1'b1);
    rd(HBPWM_OFS_CONTROL);
    chk(rv, 32'h00000408);
    rd(HBPWM_OFS_STATUS);
    chk(rv, 32'h00000003);
    wr(HBPWM_OFS_INT_CLEAR, 16'h0000);
    ck_irq(1'b1);
    fault <= 1'b0;
    repeat (5) @(posedge mclk);
    wr(HBPWM_OFS_INT_CLEAR, 16'h00aa);
    ck_irq(1'b0);
    wr(HBPWM_OFS_CONTROL, 16'h0009);
    fault <= 1'b1;
    repeat (10) @(posedge mclk);
    ck_irq(1'b0);
    rd(HBPWM_OFS_CONTROL);
    chk(rv, 32'h00000009);
    fault <= 1'b0;
    $display("test trip done");
    conclude();
  end
endmodule // hbpwm_unit_tb
